//--- cacfr_pkg.sv
// Package for the charger auxiliary control and event flag registers:
// offsets, field positions, reset values, timing figures and carriers.
// Assumes a single 200 MHz clock feeding every consumer of these names.
package cacfr_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    localparam longint unsigned CLK_HZ          = 200_000_000;
    localparam longint unsigned BUS_TIMEOUT_S   = 1;
    localparam longint unsigned BUTTON_HOLD_S   = 10;
    localparam longint unsigned EOC_SHORT_MS    = 2;
    localparam longint unsigned EOC_LONG_MS     = 64;
    localparam longint unsigned BUS_TIMEOUT_CYC = BUS_TIMEOUT_S * CLK_HZ;
    localparam longint unsigned BUTTON_HOLD_CYC = BUTTON_HOLD_S * CLK_HZ;
    localparam longint unsigned EOC_SHORT_CYC   = EOC_SHORT_MS * CLK_HZ / 1000;
    localparam longint unsigned EOC_LONG_CYC    = EOC_LONG_MS * CLK_HZ / 1000;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] ADAPTER_VOLTAGE_REQUEST = 8'h49;
    localparam logic [7:0] AUX_CONTROL_0           = 8'h4A;
    localparam logic [7:0] AUX_CONTROL_1           = 8'h4B;
    localparam logic [7:0] AUX_CONTROL_2           = 8'h4C;
    localparam logic [7:0] EVENT_FLAGS_6           = 8'h4D;
    localparam logic [7:0] EVENT_MASKS_6           = 8'h4E;

    // ==========================================================
    // Reset values and write masks
    // ==========================================================
    localparam logic [7:0] REQ_RST      = 8'h00;
    localparam logic [7:0] CTRL0_RST    = 8'h76;
    localparam logic [7:0] CTRL1_RST    = 8'h00;
    localparam logic [7:0] CTRL1_WMASK  = 8'h1F;
    localparam logic [7:0] CTRL1_WDTMSK = 8'h0F;
    localparam logic [7:0] CTRL2_RST    = 8'h4C;
    localparam logic [7:0] FLAGS_RST    = 8'h00;
    localparam logic [7:0] MASKS_RST    = 8'hFF;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int REQ_START    = 7;
    localparam int REQ_GEN2     = 6;
    localparam int REQ_STEP_UP  = 5;
    localparam int CODE_HI      = 4;
    localparam int C0_BUS_TO_DIS = 7;
    localparam int C0_BTN_RST   = 6;
    localparam int C0_AUTO_ICL  = 5;
    localparam int C0_EOC_LONG  = 4;
    localparam int C0_EOC_REARM = 3;
    localparam int C0_AUTO_MINV = 2;
    localparam int C0_COOL_SEL  = 1;
    localparam int C0_EXT_CONT  = 0;
    localparam int C1_FREQ_OVR  = 4;
    localparam int C1_PIN_FN    = 3;
    localparam int C1_QUAL      = 2;
    localparam int C2_DET_AUX2  = 7;
    localparam int C2_DCD_HI    = 6;
    localparam int C2_DCD_LO    = 5;
    localparam int C2_HIGH_REF  = 4;
    localparam int C2_HYST      = 3;
    localparam int C2_SPECIAL   = 2;
    localparam int F_TERM       = 7;
    localparam int F_SHORT      = 6;
    localparam int F_REGFAULT   = 5;
    localparam int F_NEG_DONE   = 4;
    localparam int F_SAG        = 3;
    localparam int F_RECHARGE   = 2;
    localparam int F_PORT_PRI   = 1;
    localparam int F_PORT_DONE  = 0;

    // ==========================================================
    // Encodings
    // ==========================================================
    localparam logic [4:0] GEN2_MAX_VOLT  = 5'h1D;
    localparam logic [4:0] GEN2_SELF_TEST = 5'h1E;
    localparam logic [4:0] GEN2_DROP_OFF  = 5'h1F;
    localparam logic [1:0] SEAM_VBUS      = 2'h1;
    localparam logic [1:0] SEAM_AUX1      = 2'h2;
    localparam logic [1:0] SEAM_AUX2      = 2'h3;
    localparam logic [1:0] DCD_300        = 2'h1;
    localparam logic [1:0] DCD_600        = 2'h2;
    localparam logic [1:0] DCD_WAIT       = 2'h3;
    localparam logic [1:0] HOST_FLOAT     = 2'h0;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic       protoStart;
        logic       protoGen2;
        logic       gen1StepUp;
        logic       gen2VoltReq;
        logic [4:0] gen2Code;
        logic       gen2SelfTest;
        logic       gen2DropCompOff;
        logic       busTimeoutReset;
        logic       shipOff;
        logic       autoIclSet;
        logic       autoMinVinSet;
        logic       eocReached;
        logic       battRegUseWarm;
        logic       stopChargeOtg;
        logic       forceOneMhz;
        logic       sourceModeOn;
        logic       seamlessVbus;
        logic       seamlessAux1;
        logic       seamlessAux2;
        logic       detectOnAuxTwo;
        logic       contactTimeoutOn;
        logic       contactTimeoutLong;
        logic       contactWaitForever;
        logic       primaryHighRef;
        logic       dataLineHyst;
        logic       specialAdapterDetect;
        logic [1:0] hostPortMode;
    } cacfr_ctrl_type;

    typedef struct packed {
        logic termCurrent;
        logic sysShort;
        logic regFault;
        logic negotiationDone;
        logic inputSag;
        logic portPrimary;
        logic portDone;
    } cacfr_event_type;

    typedef struct packed {
        logic coolZone;
        logic coldZone;
        logic hotZone;
    } cacfr_temp_type;

endpackage

//--- cacfr_regs.sv
// Charger auxiliary control and event flag register bank with its
// decoded controls, hold timers, end-of-charge deglitch and interrupt.
// Assumes the bus target core presents one-cycle read and write strobes
// and that all inputs are synchronous to clk.
//
// Functional notes
// - Generation select bit picks first (0) or second (1) generation request.
// - First generation step bit: 0 asks voltage down, 1 asks up.
// - Second generation codes 00000..11101 request 5.5 V up to 20 V.
// - Code 11110 runs adapter self-test; 11111 disables cable drop compensation.
// - Bus timeout enabled at 0: SDA held low 1 s resets target logic.
// - Button reset enabled: button low 10 s turns ship switch off.
// - Auto input current limit set after detection done when enabled.
// - End-of-charge deglitch is 2 ms at 0, 64 ms at 1.
// - Writing 1 re-arms end-of-charge; bit clears itself when done.
// - Auto minimum input voltage set on plug-in when enabled.
// - Cool zone uses warm setting at 0, normal setting at 1.
// - Cold or hot stops charge and source unless continue bit is 1.
// - Override bit forces 1 MHz, else normal frequency select applies.
// - Source mode follows enable bit, or bit, pin function bit and pin when qualified.
// - Seamless field: off, VBUS, aux input one, aux input two.
// - Detection runs on aux input one at 0, two at 1.
// - Contact timer: off, 300 ms, 600 ms, or wait forever.
// - Detection option bits default off, on, on; active at 1.
// - Host port emulation in source mode: float, SDP, CDP, DCP.
// - Event flags latch their events and clear on read.
// - Recharge flag sets when battery drops below threshold after EOC.
// - Mask bit 1 suppresses its flag's interrupt; masks reset to 1.
// - Start bit launches request, cleared on completion or VBUS loss.
`timescale 1ns/10ps
module cacfr_regs #(
    parameter longint unsigned BUS_TIMEOUT_CYC = cacfr_pkg::BUS_TIMEOUT_CYC,
    parameter longint unsigned BUTTON_HOLD_CYC = cacfr_pkg::BUTTON_HOLD_CYC,
    parameter longint unsigned EOC_SHORT_CYC   = cacfr_pkg::EOC_SHORT_CYC,
    parameter longint unsigned EOC_LONG_CYC    = cacfr_pkg::EOC_LONG_CYC
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      wdtReset,
    input  wire logic                      regReset,
    // Register port of the bus target
    input  wire logic [7:0]                regAddr,
    input  wire logic [7:0]                regWrData,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [7:0]                regRdData,
    // Analog and system status
    input  wire logic                      sdaHeldLow,
    input  wire logic                      pushButtonLow,
    input  wire logic                      vbusPresent,
    input  wire logic                      vbusPlugIn,
    input  wire logic                      detectDone,
    input  wire logic                      eocCondition,
    input  wire logic                      battBelowRecharge,
    input  wire logic                      sourceModeEnableBit,
    input  wire logic                      sourcePin,
    input  wire cacfr_pkg::cacfr_temp_type tempZone,
    input  wire cacfr_pkg::cacfr_event_type events,
    // Decoded controls and interrupt
    output cacfr_pkg::cacfr_ctrl_type      ctrlOut,
    output logic                           irq
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (BUS_TIMEOUT_CYC < 2 || BUTTON_HOLD_CYC < 2 ||
        EOC_SHORT_CYC < 1 || EOC_LONG_CYC < EOC_SHORT_CYC ||
        BUTTON_HOLD_CYC > 64'hFFFF_FFFF || BUS_TIMEOUT_CYC > 64'hFFFF_FFFF ||
        EOC_LONG_CYC > 64'hFFFF_FFFF) begin : gBadParam
        $error("cacfr_regs: timing parameters out of range");
    end

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [7:0]                 req;
        logic [7:0]                 ctrl0;
        logic [7:0]                 ctrl1;
        logic [7:0]                 ctrl2;
        logic [7:0]                 flags;
        logic [7:0]                 masks;
        logic [7:0]                 rdData;
        logic [31:0]                sdaCnt;
        logic [31:0]                btnCnt;
        logic [31:0]                eocCnt;
        logic                       eocDone;
        logic                       rechgPrev;
        logic                       irq;
        cacfr_pkg::cacfr_ctrl_type  outs;
    } cacfr_state_type;

    cacfr_state_type stateReg;
    cacfr_state_type stateNext;

    localparam logic [31:0] SDA_LIMIT = 32'(BUS_TIMEOUT_CYC);
    localparam logic [31:0] BTN_LIMIT = 32'(BUTTON_HOLD_CYC);
    localparam logic [31:0] EOC_SHORT = 32'(EOC_SHORT_CYC);
    localparam logic [31:0] EOC_LONG  = 32'(EOC_LONG_CYC);

    // Read mux, used only by the read path; the read check samples the flags itself
    function automatic logic [7:0] readMux(input cacfr_state_type s,
                                           input logic [7:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            cacfr_pkg::ADAPTER_VOLTAGE_REQUEST: d = s.req;
            cacfr_pkg::AUX_CONTROL_0:           d = s.ctrl0;
            cacfr_pkg::AUX_CONTROL_1:           d = s.ctrl1;
            cacfr_pkg::AUX_CONTROL_2:           d = s.ctrl2;
            cacfr_pkg::EVENT_FLAGS_6:           d = s.flags;
            cacfr_pkg::EVENT_MASKS_6:           d = s.masks;
            default:                            d = 8'h00;
        endcase
        return d;
    endfunction

    // ==========================================================
    // Next state
    // ==========================================================
    logic       wrReq;
    logic       wrC0;
    logic       rdFlags;
    logic       rechgNow;
    logic [7:0] evt;
    logic [31:0] eocLimit;
    logic [4:0] code;
    logic [1:0] seam;
    logic [1:0] dcd;

    always_comb begin
        stateNext = stateReg;
        wrReq    = regWr && regAddr == cacfr_pkg::ADAPTER_VOLTAGE_REQUEST;
        wrC0     = regWr && regAddr == cacfr_pkg::AUX_CONTROL_0;
        rdFlags  = regRd && regAddr == cacfr_pkg::EVENT_FLAGS_6;
        rechgNow = battBelowRecharge && stateReg.eocDone;
        eocLimit = stateReg.ctrl0[cacfr_pkg::C0_EOC_LONG] ?
                   EOC_LONG : EOC_SHORT;
        stateNext.outs.busTimeoutReset = 1'b0;
        stateNext.outs.shipOff         = 1'b0;

        // Hardware clears; a same-cycle write below takes precedence
        if (events.negotiationDone || !vbusPresent) begin
            stateNext.req[cacfr_pkg::REQ_START] = 1'b0;
        end
        if (stateReg.ctrl0[cacfr_pkg::C0_EOC_REARM]) begin
            stateNext.ctrl0[cacfr_pkg::C0_EOC_REARM] = 1'b0;
            stateNext.eocDone = 1'b0;
            stateNext.eocCnt  = '0;
        end else if (!eocCondition) begin
            stateNext.eocCnt = '0;
        end else if (!stateReg.eocDone) begin
            if (stateReg.eocCnt >= eocLimit - 32'h1) begin
                stateNext.eocDone = 1'b1;
            end else begin
                stateNext.eocCnt = stateReg.eocCnt + 32'h1;
            end
        end

        // Register writes
        if (wrReq) begin
            stateNext.req = regWrData;
        end
        if (wrC0) begin
            stateNext.ctrl0 = {regWrData[7:4],
                stateNext.ctrl0[cacfr_pkg::C0_EOC_REARM] |
                regWrData[cacfr_pkg::C0_EOC_REARM],
                regWrData[2:0]};
        end
        if (regWr && regAddr == cacfr_pkg::AUX_CONTROL_1) begin
            stateNext.ctrl1 = regWrData & cacfr_pkg::CTRL1_WMASK;
        end
        if (regWr && regAddr == cacfr_pkg::AUX_CONTROL_2) begin
            stateNext.ctrl2 = regWrData;
        end
        if (regWr && regAddr == cacfr_pkg::EVENT_MASKS_6) begin
            stateNext.masks = regWrData;
        end

        // Watchdog and register resets
        if (wdtReset || regReset) begin
            stateNext.req   = cacfr_pkg::REQ_RST;
            stateNext.ctrl0 = cacfr_pkg::CTRL0_RST;
            stateNext.ctrl2 = cacfr_pkg::CTRL2_RST;
            stateNext.masks = cacfr_pkg::MASKS_RST;
            stateNext.ctrl1 = stateNext.ctrl1 &
                              ~cacfr_pkg::CTRL1_WDTMSK;
        end
        if (regReset) begin
            stateNext.ctrl1 = cacfr_pkg::CTRL1_RST;
        end

        // Event flags: a set in the read cycle survives the clear
        evt = 8'h00;
        evt[cacfr_pkg::F_TERM]      = events.termCurrent;
        evt[cacfr_pkg::F_SHORT]     = events.sysShort;
        evt[cacfr_pkg::F_REGFAULT]  = events.regFault;
        evt[cacfr_pkg::F_NEG_DONE]  = events.negotiationDone;
        evt[cacfr_pkg::F_SAG]       = events.inputSag;
        evt[cacfr_pkg::F_RECHARGE]  = rechgNow && !stateReg.rechgPrev;
        evt[cacfr_pkg::F_PORT_PRI]  = events.portPrimary;
        evt[cacfr_pkg::F_PORT_DONE] = events.portDone;
        stateNext.rechgPrev = rechgNow;
        stateNext.flags = (rdFlags ? 8'h00 : stateReg.flags) | evt;
        stateNext.irq   = |(stateNext.flags & ~stateNext.masks);

        if (regRd) begin
            stateNext.rdData = readMux(stateReg, regAddr);
        end

        // Bus hold timer fires once per low period
        if (sdaHeldLow && !stateReg.ctrl0[cacfr_pkg::C0_BUS_TO_DIS]) begin
            if (stateReg.sdaCnt < SDA_LIMIT) begin
                stateNext.sdaCnt = stateReg.sdaCnt + 32'h1;
            end
            stateNext.outs.busTimeoutReset =
                stateReg.sdaCnt == SDA_LIMIT - 32'h1;
        end else begin
            stateNext.sdaCnt = '0;
        end

        // Button hold timer, same one-shot shape
        if (pushButtonLow && stateReg.ctrl0[cacfr_pkg::C0_BTN_RST]) begin
            if (stateReg.btnCnt < BTN_LIMIT) begin
                stateNext.btnCnt = stateReg.btnCnt + 32'h1;
            end
            stateNext.outs.shipOff =
                stateReg.btnCnt == BTN_LIMIT - 32'h1;
        end else begin
            stateNext.btnCnt = '0;
        end

        // Decoded controls
        code = stateNext.req[cacfr_pkg::CODE_HI:0];
        seam = stateNext.ctrl1[1:0];
        dcd  = stateNext.ctrl2[cacfr_pkg::C2_DCD_HI:cacfr_pkg::C2_DCD_LO];
        stateNext.outs.protoStart = stateNext.req[cacfr_pkg::REQ_START];
        stateNext.outs.protoGen2  = stateNext.req[cacfr_pkg::REQ_GEN2];
        stateNext.outs.gen1StepUp = stateNext.req[cacfr_pkg::REQ_STEP_UP];
        stateNext.outs.gen2Code     = code;
        stateNext.outs.gen2VoltReq  = code <= cacfr_pkg::GEN2_MAX_VOLT;
        stateNext.outs.gen2SelfTest = code == cacfr_pkg::GEN2_SELF_TEST;
        stateNext.outs.gen2DropCompOff = code == cacfr_pkg::GEN2_DROP_OFF;
        stateNext.outs.autoIclSet = detectDone &&
            stateNext.ctrl0[cacfr_pkg::C0_AUTO_ICL];
        stateNext.outs.autoMinVinSet = vbusPlugIn &&
            stateNext.ctrl0[cacfr_pkg::C0_AUTO_MINV];
        stateNext.outs.eocReached = stateNext.eocDone;
        stateNext.outs.battRegUseWarm = tempZone.coolZone &&
            !stateNext.ctrl0[cacfr_pkg::C0_COOL_SEL];
        stateNext.outs.stopChargeOtg =
            (tempZone.coldZone || tempZone.hotZone) &&
            !stateNext.ctrl0[cacfr_pkg::C0_EXT_CONT];
        stateNext.outs.forceOneMhz =
            stateNext.ctrl1[cacfr_pkg::C1_FREQ_OVR];
        stateNext.outs.sourceModeOn = sourceModeEnableBit &&
            (!stateNext.ctrl1[cacfr_pkg::C1_QUAL] ||
             (stateNext.ctrl1[cacfr_pkg::C1_PIN_FN] && sourcePin));
        stateNext.outs.seamlessVbus = seam == cacfr_pkg::SEAM_VBUS;
        stateNext.outs.seamlessAux1 = seam == cacfr_pkg::SEAM_AUX1;
        stateNext.outs.seamlessAux2 = seam == cacfr_pkg::SEAM_AUX2;
        stateNext.outs.detectOnAuxTwo =
            stateNext.ctrl2[cacfr_pkg::C2_DET_AUX2];
        stateNext.outs.contactTimeoutOn =
            dcd == cacfr_pkg::DCD_300 || dcd == cacfr_pkg::DCD_600;
        stateNext.outs.contactTimeoutLong = dcd == cacfr_pkg::DCD_600;
        stateNext.outs.contactWaitForever = dcd == cacfr_pkg::DCD_WAIT;
        stateNext.outs.primaryHighRef =
            stateNext.ctrl2[cacfr_pkg::C2_HIGH_REF];
        stateNext.outs.dataLineHyst = stateNext.ctrl2[cacfr_pkg::C2_HYST];
        stateNext.outs.specialAdapterDetect =
            stateNext.ctrl2[cacfr_pkg::C2_SPECIAL];
        stateNext.outs.hostPortMode = stateNext.outs.sourceModeOn ?
            stateNext.ctrl2[1:0] : cacfr_pkg::HOST_FLOAT;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stateReg       <= '0;
            stateReg.req   <= cacfr_pkg::REQ_RST;
            stateReg.ctrl0 <= cacfr_pkg::CTRL0_RST;
            stateReg.ctrl1 <= cacfr_pkg::CTRL1_RST;
            stateReg.ctrl2 <= cacfr_pkg::CTRL2_RST;
            stateReg.flags <= cacfr_pkg::FLAGS_RST;
            stateReg.masks <= cacfr_pkg::MASKS_RST;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign regRdData = stateReg.rdData;
    assign ctrlOut   = stateReg.outs;
    assign irq       = stateReg.irq;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence flagReadQuiet;
        regRd && regAddr == cacfr_pkg::EVENT_FLAGS_6 && !(|evt);
    endsequence

    sequence rearmIdle;
        stateReg.ctrl0[cacfr_pkg::C0_EOC_REARM] && !wrC0;
    endsequence

    flags_read_clear_a: assert property (flagReadQuiet |=>
        stateReg.flags == 8'h00 && irq == 1'b0)
        else $error("flags not cleared by read");

    masks_after_reset_a: assert property ($past(!rst_b) |->
        stateReg.masks == 8'hFF && !irq)
        else $error("masks not set after reset");

    irq_unmasked_a: assert property (
        |(evt & ~stateReg.masks) && !wdtReset && !regReset &&
        !(regWr && regAddr == cacfr_pkg::EVENT_MASKS_6) |=> irq)
        else $error("unmasked flag without interrupt");

    start_clear_a: assert property (
        stateReg.req[cacfr_pkg::REQ_START] && !vbusPresent && !wrReq
        |=> !ctrlOut.protoStart)
        else $error("start bit kept without VBUS");

    rearm_self_clear_a: assert property (rearmIdle |=>
        !stateReg.ctrl0[cacfr_pkg::C0_EOC_REARM] && !ctrlOut.eocReached)
        else $error("re-arm bit did not clear");

    extreme_stop_a: assert property (
        tempZone.hotZone && !stateReg.ctrl0[cacfr_pkg::C0_EXT_CONT] &&
        !wrC0 && !wdtReset && !regReset |=> ctrlOut.stopChargeOtg)
        else $error("hot zone did not stop charging");

    bus_timeout_cause_a: assert property (
        ctrlOut.busTimeoutReset |-> $past(sdaHeldLow, 1) &&
        $past(stateReg.sdaCnt, 1) == SDA_LIMIT - 32'h1)
        else $error("bus reset without full hold");

    button_once_a: assert property (
        ctrlOut.shipOff |=> !ctrlOut.shipOff)
        else $error("ship-off pulse longer than one cycle");

    read_data_a: assert property (
        regRd && regAddr == cacfr_pkg::EVENT_FLAGS_6 |=>
        regRdData == $past(stateReg.flags))
        else $error("read data mismatch");

endmodule // cacfr_regs

//--- cacfr_host_model.sv
// Host side model: drives the register strobes of the bank.
// Assumes strobes are sampled on the rising edge of clk.
`timescale 1ns/10ps
module cacfr_host_model (
    // Clock and read data
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    // Register strobes
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    output logic            regWr,
    output logic            regRd
);
    initial begin
        regAddr   = 8'h00;
        regWrData = 8'h00;
        regWr     = 1'b0;
        regRd     = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr   = a;
        regWrData = d;
        regWr     = 1'b1;
        @(negedge clk);
        regWr     = 1'b0;
        // Stale data never looks valid
        regWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRd   = 1'b1;
        @(negedge clk);
        regRd   = 1'b0;
        d       = regRdData;
    endtask
endmodule // cacfr_host_model

//--- charger_aux_control_flag_regs_tb.sv
// Testbench of the charger auxiliary register bank.
// Assumes the host model owns the register port.
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    n_fail++; $display("ERROR %s exp %h got %h", n, e, a); end end
module charger_aux_control_flag_regs_tb;
    logic clk = 1'b0, rst_b = 1'b0, wdtR = 1'b0, regR = 1'b0;
    logic sdaLow = 1'b0, btnLow = 1'b0, vbus = 1'b1, plug = 1'b0;
    logic detDone = 1'b0, eoc = 1'b0, battLow = 1'b0, srcBit = 1'b0;
    logic srcPin = 1'b0, irq, regWr, regRd;
    logic [7:0] regAddr, regWrData, regRdData, v;
    cacfr_pkg::cacfr_temp_type  tz = '0;
    cacfr_pkg::cacfr_event_type ev = '0;
    cacfr_pkg::cacfr_ctrl_type  ctrl;
    int n_fail = 0, n_compared = 0;
    always #2.5 clk = ~clk;
    cacfr_host_model i_cacfr_host_model (.clk(clk), .regRdData(regRdData),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd));
    cacfr_regs #(.BUS_TIMEOUT_CYC(20), .BUTTON_HOLD_CYC(30),
        .EOC_SHORT_CYC(5), .EOC_LONG_CYC(12)) i_cacfr_regs (.clk(clk),
        .rst_b(rst_b), .wdtReset(wdtR), .regReset(regR),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .sdaHeldLow(sdaLow),
        .pushButtonLow(btnLow), .vbusPresent(vbus), .vbusPlugIn(plug),
        .detectDone(detDone), .eocCondition(eoc),
        .battBelowRecharge(battLow), .sourceModeEnableBit(srcBit),
        .sourcePin(srcPin), .tempZone(tz), .events(ev), .ctrlOut(ctrl),
        .irq(irq));
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_reset;
        logic [7:0] ad [7] = '{8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D,
                               8'h4E, 8'h50};
        logic [7:0] ex [7] = '{8'h00, 8'h76, 8'h00, 8'h4C, 8'h00,
                               8'hFF, 8'h00};
        for (int i = 0; i < 7; i++) begin
            i_cacfr_host_model.rd(ad[i], v);
            `CHK("reset value", ex[i], v)
        end
        $display("done: reset");
    endtask
    task automatic t_flags;
        @(negedge clk);
        ev = 7'h7F;
        @(negedge clk);
        ev = '0;
        `CHK("irq masked", 1'b0, irq)
        i_cacfr_host_model.wr(8'h4E, 8'h00);
        `CHK("irq unmasked", 1'b1, irq)
        i_cacfr_host_model.rd(8'h4D, v);
        `CHK("flags", 8'hFB, v)
        `CHK("irq after read", 1'b0, irq)
        i_cacfr_host_model.rd(8'h4D, v);
        `CHK("flags cleared", 8'h00, v)
        $display("done: flags");
    endtask
    task automatic t_start;
        i_cacfr_host_model.wr(8'h49, 8'h80);
        i_cacfr_host_model.rd(8'h49, v);
        `CHK("start set", 8'h80, v)
        vbus = 1'b0;
        repeat (2) @(negedge clk);
        i_cacfr_host_model.rd(8'h49, v);
        `CHK("start cleared", 8'h00, v)
        vbus = 1'b1;
        $display("done: start");
    endtask
    task automatic t_codes;
        for (logic [4:0] c = 5'h1C; c != 5'h00; c++) begin
            i_cacfr_host_model.wr(8'h49, {3'b010, c});
            `CHK("gen2", 1'b1, ctrl.protoGen2)
            `CHK("volt req", c <= 5'h1D, ctrl.gen2VoltReq)
            `CHK("self test", c == 5'h1E, ctrl.gen2SelfTest)
            `CHK("drop off", c == 5'h1F, ctrl.gen2DropCompOff)
        end
        i_cacfr_host_model.wr(8'h4A, 8'h7E);
        i_cacfr_host_model.rd(8'h4A, v);
        `CHK("rearm clears", 8'h76, v)
        $display("done: codes");
    endtask
    task automatic t_timers;
        int tS, tB, tE;
        for (int p = 0; p < 2; p++) begin
            {tS, tB, tE} = '0;
            {sdaLow, btnLow, eoc} = 3'b111;
            for (int i = 1; i <= 40; i++) begin
                @(negedge clk);
                if (ctrl.busTimeoutReset) tS = i;
                if (ctrl.shipOff) tB = i;
                if (ctrl.eocReached && tE == 0) tE = i;
            end
            `CHK("sda hold", p ? 0 : 20, tS)
            `CHK("button hold", p ? 0 : 30, tB)
            // Second pass restarts one cycle late, after the re-arm edge
            `CHK("eoc deglitch", p ? 6 : 12, tE)
            if (p == 0) begin
                battLow = 1'b1;
                @(negedge clk);
                battLow = 1'b0;
                `CHK("irq recharge", 1'b1, irq)
                i_cacfr_host_model.rd(8'h4D, v);
                `CHK("recharge flag", 8'h04, v)
            end
            {sdaLow, btnLow, eoc} = 3'b000;
            i_cacfr_host_model.wr(8'h4A, p ? 8'h76 : 8'hAE);
        end
        $display("done: timers");
    endtask
    task automatic t_ctrl;
        tz = 3'b101;
        srcBit = 1'b1;
        // Slices follow the field order of the control carrier
        i_cacfr_host_model.wr(8'h4A, 8'h74);
        `CHK("zone outs", 2'h3, ctrl[15:14])
        i_cacfr_host_model.wr(8'h4B, 8'hFE);
        `CHK("ctrl1 outs", 5'h12, ctrl[13:9])
        srcPin = 1'b1;
        i_cacfr_host_model.wr(8'h4C, 8'hFF);
        `CHK("ctrl2 outs", 9'h13F, ctrl[8:0])
        {plug, detDone} = 2'b11;
        @(negedge clk);
        {plug, detDone} = 2'b00;
        `CHK("auto sets", 2'h3, ctrl[18:17])
        i_cacfr_host_model.wr(8'h49, 8'h20);
        `CHK("gen1 step", 3'h1, ctrl[31:29])
        wdtR = 1'b1;
        @(negedge clk);
        wdtR = 1'b0;
        i_cacfr_host_model.rd(8'h4B, v);
        `CHK("wdt keeps 1MHz", 8'h10, v)
        regR = 1'b1;
        @(negedge clk);
        regR = 1'b0;
        i_cacfr_host_model.rd(8'h4B, v);
        `CHK("reg rst 1MHz", 8'h00, v)
        {tz, srcBit, srcPin} = '0;
        $display("done: ctrl");
    endtask
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        t_reset;
        t_flags;
        t_start;
        t_codes;
        t_timers;
        t_ctrl;
        stop_test;
    end
    initial begin
        #20000;
        n_fail++;
        stop_test;
    end
endmodule // charger_aux_control_flag_regs_tb
